// File: hdl/ledi2c_slave.sv
// I2C register slave for a six-channel LED current driver
`timescale 1ns/10ps
`default_nettype none
`include "ledi2c_consts.svh"
// What this block does
// - Registers accessed only while enable high
// - Enable low stops interface, clears channel and pump outputs
// - Slave only, never drives clock
// - Answers fixed address 1100110, R/W bit
// - Write: address, register, data, stop
// - Read: register, restart, one byte, nack
// - Acknowledge address, register and data bytes
// - Registers 0..2 hold pair current codes
// - Code maps linearly 0.5 to 32 mA
// - Register 3 bits 0..5 enable channels
// - Register 3 bit 6 selects pump frequency
// - Unused bits ignore writes, read zero
// - Current codes not reset, kept disabled
module ledi2c_slave
  import ledi2c_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic chip_en_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n_out,
  output logic [5:0] pair_a_current_code_out,
  output logic [5:0] pair_b_current_code_out,
  output logic [5:0] pair_c_current_code_out,
  output logic [15:0] pair_a_current_ua_out,
  output logic channel_a_first_on_out,
  output logic channel_a_second_on_out,
  output logic channel_b_first_on_out,
  output logic channel_b_second_on_out,
  output logic channel_c_first_on_out,
  output logic channel_c_second_on_out,
  output logic pump_frequency_select_out,
  output logic active_out
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  always_ff @(posedge clk_in)
  begin
    s1_ff <= {chip_en_in, scl_in, sda_in};
    s2_ff <= s1_ff;
    scl_d_ff <= s2_ff[1];
    sda_d_ff <= s2_ff[0];
  end
  logic en_s;
  logic scl_s;
  logic sda_s;
  assign en_s = s2_ff[2];
  assign scl_s = s2_ff[1];
  assign sda_s = s2_ff[0];
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Protocol engine
  ledi2c_state_e st_ff, nxt_st;
  logic [7:0] sh_ff, nxt_sh;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] ptr_ff, nxt_ptr;
  logic phase_ff, nxt_phase;
  logic rd_ff, nxt_rd;
  logic oe_n_ff, nxt_oe_n;
  logic [6:0] en_reg_ff, nxt_en_reg;
  logic code_we;
  logic [5:0] code_rd;
  logic [17:0] codes;

  function automatic logic [7:0] rd_val(input logic [7:0] a,
                                        input logic [5:0] c,
                                        input logic [6:0] e);
    logic [7:0] v;
    v = 8'h00;
    if (a < `LEDI2C_OFS_ENABLE)
    begin
      v = {2'b00, c};
    end
    else if (a == `LEDI2C_OFS_ENABLE)
    begin
      v = {1'b0, e};
    end
    return v;
  endfunction
  // Byte offered to the master on a read, loaded at the address ack
  logic [7:0] tx_byte;
  assign tx_byte = rd_val(ptr_ff, code_rd, en_reg_ff);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_ptr = ptr_ff;
    nxt_phase = phase_ff;
    nxt_rd = rd_ff;
    nxt_oe_n = oe_n_ff;
    nxt_en_reg = en_reg_ff;
    code_we = 1'b0;
    if (!en_s)
    begin
      // Shutdown: bus released, channels off, codes kept
      nxt_st = LEDI2C_IDLE;
      nxt_oe_n = 1'b1;
      nxt_en_reg = `LEDI2C_ENABLE_RST;
    end
    else if (start_c)
    begin
      nxt_st = LEDI2C_ADDR;
      nxt_cnt = 4'h0;
      nxt_oe_n = 1'b1;
    end
    else if (stop_c)
    begin
      nxt_st = LEDI2C_IDLE;
      nxt_oe_n = 1'b1;
    end
    else
    begin
      unique case (st_ff)
        LEDI2C_IDLE, LEDI2C_IGN:
        begin
          nxt_oe_n = 1'b1;
        end
        LEDI2C_ADDR:
        begin
          if (scl_rise)
          begin
            nxt_sh = {sh_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (scl_fall && cnt_ff == 4'h8)
          begin
            if (sh_ff[7:1] == `LEDI2C_SLAVE_ADDR)
            begin
              nxt_rd = sh_ff[0];
              nxt_phase = 1'b0;
              nxt_oe_n = 1'b0;
              nxt_st = LEDI2C_ACK;
            end
            else
            begin
              nxt_st = LEDI2C_IGN;
            end
          end
        end
        LEDI2C_ACK:
        begin
          if (scl_fall)
          begin
            nxt_cnt = 4'h0;
            if (rd_ff)
            begin
              nxt_sh = tx_byte;
              nxt_oe_n = tx_byte[7];
              nxt_st = LEDI2C_TXB;
            end
            else
            begin
              nxt_oe_n = 1'b1;
              nxt_st = LEDI2C_RXB;
            end
          end
        end
        LEDI2C_RXB:
        begin
          if (scl_rise)
          begin
            nxt_sh = {sh_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (scl_fall && cnt_ff == 4'h8)
          begin
            nxt_oe_n = 1'b0;
            nxt_st = LEDI2C_ACK;
            if (!phase_ff)
            begin
              nxt_ptr = sh_ff;
              nxt_phase = 1'b1;
            end
            else if (ptr_ff == `LEDI2C_OFS_ENABLE)
            begin
              nxt_en_reg = sh_ff[6:0];
            end
            else
            begin
              code_we = (ptr_ff < `LEDI2C_OFS_ENABLE);
            end
          end
        end
        LEDI2C_TXB:
        begin
          if (scl_rise)
          begin
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt_ff == 4'h8)
            begin
              nxt_oe_n = 1'b1;
              nxt_st = LEDI2C_MACK;
            end
            else
            begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_oe_n = sh_ff[6];
            end
          end
        end
        LEDI2C_MACK:
        begin
          // Single byte per read; master nack then stop ends it
          if (scl_rise)
          begin
            nxt_st = LEDI2C_IGN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_ff <= LEDI2C_IDLE;
      sh_ff <= 8'h00;
      cnt_ff <= 4'h0;
      ptr_ff <= 8'h00;
      phase_ff <= 1'b0;
      rd_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      en_reg_ff <= `LEDI2C_ENABLE_RST;
    end
    else
    begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      ptr_ff <= nxt_ptr;
      phase_ff <= nxt_phase;
      rd_ff <= nxt_rd;
      oe_n_ff <= nxt_oe_n;
      en_reg_ff <= nxt_en_reg;
    end
  end

  ledi2c_regbank #(.DEPTH(3)) ledi2c_regbank_inst (
    .clk_in(clk_in),
    .wr_en_in(code_we),
    .wr_idx_in(ptr_ff[1:0]),
    .wr_data_in(sh_ff[5:0]),
    .rd_idx_in(ptr_ff[1:0]),
    .rd_data_out(code_rd),
    .all_out(codes)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs to the analog side
  logic [15:0] ua_ff;
  logic act_ff;
  // Checker helper: pair A code has been written since reset
  logic code_a_known_ff;
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      ua_ff <= 16'h0000;
      act_ff <= 1'b0;
      code_a_known_ff <= 1'b0;
    end
    else
    begin
      ua_ff <= 16'(`LEDI2C_BASE_UA + `LEDI2C_STEP_UA * codes[5:0]);
      act_ff <= en_s;
      if (code_we && ptr_ff == `LEDI2C_OFS_PAIR_A)
      begin
        code_a_known_ff <= 1'b1;
      end
    end
  end
  assign sda_oe_n_out = oe_n_ff;
  assign pair_a_current_code_out = codes[5:0];
  assign pair_b_current_code_out = codes[11:6];
  assign pair_c_current_code_out = codes[17:12];
  assign pair_a_current_ua_out = ua_ff;
  assign channel_a_first_on_out = en_reg_ff[0];
  assign channel_a_second_on_out = en_reg_ff[1];
  assign channel_b_first_on_out = en_reg_ff[2];
  assign channel_b_second_on_out = en_reg_ff[3];
  assign channel_c_first_on_out = en_reg_ff[4];
  assign channel_c_second_on_out = en_reg_ff[5];
  assign pump_frequency_select_out = en_reg_ff[`LEDI2C_FREQ_BIT];
  assign active_out = act_ff;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_en_off;
    @(posedge clk_in) disable iff (sys_rst_in)
      !en_s |=> (en_reg_ff == 7'h00) && oe_n_ff && st_ff == LEDI2C_IDLE;
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("enable low not off");
  property p_idle_release;
    @(posedge clk_in) disable iff (sys_rst_in)
      st_ff == LEDI2C_IDLE |-> oe_n_ff;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("sda driven idle");
  property p_addr_ack;
    @(posedge clk_in) disable iff (sys_rst_in)
      st_ff == LEDI2C_ADDR && nxt_st == LEDI2C_ACK |->
        sh_ff[7:1] == 7'h66 && cnt_ff == 4'h8;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("acked wrong address");
  property p_ack_low;
    @(posedge clk_in) disable iff (sys_rst_in)
      st_ff == LEDI2C_ACK && $past(st_ff) != LEDI2C_ACK |-> !oe_n_ff;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("ack not driven");
  property p_en_write;
    @(posedge clk_in) disable iff (sys_rst_in)
      en_s && st_ff == LEDI2C_RXB && phase_ff && ptr_ff == 8'h03 &&
      scl_fall && cnt_ff == 4'h8 && !start_c && !stop_c
      |=> en_reg_ff == $past(sh_ff[6:0]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable write lost");
  // Unused bits and unmapped addresses leave the shifter as zero
  property p_rd_zero;
    @(posedge clk_in) disable iff (sys_rst_in)
      st_ff == LEDI2C_ACK && nxt_st == LEDI2C_TXB |=> !sh_ff[7] &&
        ($past(ptr_ff) == 8'h03 || !sh_ff[6]) &&
        ($past(ptr_ff) <= 8'h03 || sh_ff == 8'h00);
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("read value wrong");
  // Gated: codes are unknown until software writes them
  property p_ua;
    @(posedge clk_in) disable iff (sys_rst_in)
      code_a_known_ff |=> ua_ff == 16'(500 + 500 * $past(codes[5:0]));
  endproperty
  a_ua: assert property (p_ua)
    else $error("current map wrong");
  property p_freq;
    @(posedge clk_in) disable iff (sys_rst_in)
      st_ff == LEDI2C_RXB && phase_ff && ptr_ff == 8'h03 &&
      nxt_st == LEDI2C_ACK
      |=> pump_frequency_select_out == $past(sh_ff[6]);
  endproperty
  a_freq: assert property (p_freq)
    else $error("pump select not stored");
  property p_tx_release;
    @(posedge clk_in) disable iff (sys_rst_in)
      st_ff == LEDI2C_MACK |-> oe_n_ff;
  endproperty
  a_tx_release: assert property (p_tx_release)
    else $error("nack driven");
  c_write: cover property (@(posedge clk_in) code_we);
  c_read: cover property (@(posedge clk_in) st_ff == LEDI2C_TXB);
  c_en_reg: cover property (@(posedge clk_in) en_reg_ff[6]);
endmodule
`default_nettype wire

// File: hdl/ledi2c_consts.svh
// Register offsets, field positions and fixed values of the LED I2C slave
`ifndef LEDI2C_CONSTS_SVH
`define LEDI2C_CONSTS_SVH
`define LEDI2C_SLAVE_ADDR 7'h66
`define LEDI2C_OFS_PAIR_A 8'h00
`define LEDI2C_OFS_PAIR_B 8'h01
`define LEDI2C_OFS_PAIR_C 8'h02
`define LEDI2C_OFS_ENABLE 8'h03
`define LEDI2C_REG_COUNT 4
`define LEDI2C_CODE_MSB 5
`define LEDI2C_FREQ_BIT 6
`define LEDI2C_EN_MSB 5
`define LEDI2C_ENABLE_RST 7'h00
`define LEDI2C_STEP_UA 500
`define LEDI2C_BASE_UA 500
`endif

// File: hdl/ledi2c_pkg.sv
// Types shared by the LED I2C slave
package ledi2c_pkg;
  typedef enum logic [6:0] {
    LEDI2C_IDLE = 7'b000_0001,
    LEDI2C_ADDR = 7'b000_0010,
    LEDI2C_ACK = 7'b000_0100,
    LEDI2C_RXB = 7'b000_1000,
    LEDI2C_TXB = 7'b001_0000,
    LEDI2C_MACK = 7'b010_0000,
    LEDI2C_IGN = 7'b100_0000
  } ledi2c_state_e;
  typedef logic [5:0] ledi2c_code_t;
endpackage

// File: hdl/ledi2c_regbank.sv
// Small register bank holding the three current codes
`timescale 1ns/10ps
`default_nettype none
module ledi2c_regbank
  import ledi2c_pkg::*;
#(
  parameter int DEPTH = 3
)
(
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [1:0] wr_idx_in,
  input wire logic [5:0] wr_data_in,
  input wire logic [1:0] rd_idx_in,
  output logic [5:0] rd_data_out,
  output logic [6*DEPTH-1:0] all_out
);
  // No reset: codes are undefined at power-up and survive enable low
  logic [5:0] mem_ff [DEPTH];
  logic [5:0] rd_ff;
  always_ff @(posedge clk_in)
  begin
    if (wr_en_in && (int'(wr_idx_in) < DEPTH))
    begin
      mem_ff[wr_idx_in] <= wr_data_in;
    end
    rd_ff <= (int'(rd_idx_in) < DEPTH) ? mem_ff[rd_idx_in] : 6'h00;
  end
  assign rd_data_out = rd_ff;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_out
      assign all_out[6*g +: 6] = mem_ff[g];
    end
  endgenerate
endmodule
`default_nettype wire

// File: sim/ledi2c_mst.sv
// Behavioural I2C bus master facing the LED register slave
`timescale 1ns/10ps
`default_nettype none
module ledi2c_mst
(
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_n_out
);
  // Clock stands high between frames; only this side drives it
  initial
  begin
    scl_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  // Low 80 ns, high 80 ns; read late in high so slow answers settle
  task automatic bit_x(input logic b, output logic r);
    sda_oe_n_out = b;
    #60;
    scl_out = 1'b1;
    #70;
    r = sda_in;
    #10;
    scl_out = 1'b0;
    #20;
  endtask
  // Serves as start and repeated start
  task automatic start_c();
    @(posedge clk_in);
    #2;
    sda_oe_n_out = 1'b1;
    #20;
    scl_out = 1'b1;
    #60;
    sda_oe_n_out = 1'b0;
    #60;
    scl_out = 1'b0;
    #20;
  endtask
  task automatic stop_c();
    sda_oe_n_out = 1'b0;
    #60;
    scl_out = 1'b1;
    #60;
    sda_oe_n_out = 1'b1;
    #80;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule
`default_nettype wire

// File: sim/ledi2c_slave_tb.sv
// Self-checking bench for the LED I2C register slave
`timescale 1ns/10ps
`default_nettype none
`include "ledi2c_consts.svh"
module ledi2c_slave_tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic chip_en_in = 1'b1;
  logic scl, m_oe_n, s_oe_n, sda_w, pump, active;
  logic [5:0] code_a, code_b, code_c, ch;
  logic [15:0] ua;
  logic [7:0] sh [4];
  logic [7:0] corner [3] = '{8'hC0, 8'hFF, 8'h41};
  int seed = 71827;
  int miscompares = 0;
  int n_compared = 0;
  always #10 clk_in = ~clk_in;
  // Pull-up: low when either side pulls
  assign sda_w = m_oe_n & s_oe_n;
  ledi2c_mst ledi2c_mst_inst (.clk_in(clk_in), .sda_in(sda_w),
    .scl_out(scl), .sda_oe_n_out(m_oe_n));
  ledi2c_slave ledi2c_slave_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .chip_en_in(chip_en_in),
    .scl_in(scl), .sda_in(sda_w), .sda_oe_n_out(s_oe_n),
    .pair_a_current_code_out(code_a), .pair_b_current_code_out(code_b),
    .pair_c_current_code_out(code_c), .pair_a_current_ua_out(ua),
    .channel_a_first_on_out(ch[0]), .channel_a_second_on_out(ch[1]),
    .channel_b_first_on_out(ch[2]), .channel_b_second_on_out(ch[3]),
    .channel_c_first_on_out(ch[4]), .channel_c_second_on_out(ch[5]),
    .pump_frequency_select_out(pump), .active_out(active));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a < 8'h03)
      return {2'b00, sh[a[1:0]][5:0]};
    if (a == 8'h03)
      return {1'b0, sh[3][6:0]};
    return 8'h00;
  endfunction
  function automatic logic [15:0] exp_ua(input logic [5:0] c);
    return 16'(`LEDI2C_BASE_UA + `LEDI2C_STEP_UA * c);
  endfunction
  task automatic reg_wr(input logic [6:0] dev, input logic [7:0] a,
                        input logic [7:0] d, output logic [2:0] k);
    ledi2c_mst_inst.start_c();
    ledi2c_mst_inst.wr_byte({dev, 1'b0}, k[2]);
    ledi2c_mst_inst.wr_byte(a, k[1]);
    ledi2c_mst_inst.wr_byte(d, k[0]);
    ledi2c_mst_inst.stop_c();
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d,
                        output logic [2:0] k);
    ledi2c_mst_inst.start_c();
    ledi2c_mst_inst.wr_byte({`LEDI2C_SLAVE_ADDR, 1'b0}, k[2]);
    ledi2c_mst_inst.wr_byte(a, k[1]);
    ledi2c_mst_inst.start_c();
    ledi2c_mst_inst.wr_byte({`LEDI2C_SLAVE_ADDR, 1'b1}, k[0]);
    ledi2c_mst_inst.rd_byte(1'b1, d);
    ledi2c_mst_inst.stop_c();
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] v);
    logic [2:0] k;
    reg_wr(`LEDI2C_SLAVE_ADDR, a, v, k);
    chk("wr_ack", 16'h0007, 16'(k));
  endtask
  task automatic rd_chk(input logic [7:0] a);
    logic [2:0] k;
    logic [7:0] d;
    reg_rd(a, d, k);
    chk("rd_ack", 16'h0007, 16'(k));
    chk("rd_data", 16'(exp_rd(a)), 16'(d));
  endtask
  task automatic chk_outs();
    chk("code_a", 16'(sh[0][5:0]), 16'(code_a));
    chk("code_b", 16'(sh[1][5:0]), 16'(code_b));
    chk("code_c", 16'(sh[2][5:0]), 16'(code_c));
    chk("ua", exp_ua(sh[0][5:0]), ua);
    chk("chan", 16'(sh[3][5:0]), 16'(ch));
    chk("pump", 16'(sh[3][6]), 16'(pump));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [2:0] k;
    logic [7:0] v;
    repeat (8) @(posedge clk_in);
    #2;
    sys_rst_in = 1'b0;
    #350000;
    chk("sda_idle", 16'h0001, 16'(s_oe_n));
    chk("reg3_rst", 16'h0000, 16'({pump, ch}));
    $display("test reset done");
    repeat (6)
    begin
      for (int i = 0; i < 4; i++)
      begin
        sh[i] = 8'($random(seed));
        wr_chk(8'(i), sh[i]);
      end
      chk_outs();
      for (int i = 0; i < 4; i++)
        rd_chk(8'(i));
    end
    $display("test random access done");
    // Code 0 and 63 ends of the current scale, unused bits set
    for (int i = 0; i < 3; i++)
    begin
      sh[0] = corner[i];
      sh[3] = corner[i];
      wr_chk(8'h00, sh[0]);
      wr_chk(8'h03, sh[3]);
      chk_outs();
      rd_chk(8'h00);
      rd_chk(8'h03);
    end
    $display("test corners done");
    v = 8'($random(seed)) | 8'h04;
    wr_chk(v, 8'h3F);
    chk_outs();
    rd_chk(v);
    $display("test high address done");
    for (int j = 0; j < 7; j++)
    begin
      reg_wr(`LEDI2C_SLAVE_ADDR ^ 7'(1 << j), 8'h03, ~sh[3], k);
      chk("bad_dev_ack", 16'h0000, 16'(k));
    end
    chk_outs();
    $display("test wrong device done");
    @(posedge clk_in);
    #2;
    chip_en_in = 1'b0;
    repeat (10) @(posedge clk_in);
    chk("active_off", 16'h0000, 16'(active));
    reg_wr(`LEDI2C_SLAVE_ADDR, 8'h00, ~sh[0], k);
    chk("off_ack", 16'h0000, 16'(k));
    sh[3] = 8'h00;
    chk_outs();
    @(posedge clk_in);
    #2;
    chip_en_in = 1'b1;
    #350000;
    chk("active_on", 16'h0001, 16'(active));
    chk_outs();
    rd_chk(8'h03);
    $display("test enable off done");
    print_verdict();
  end
  // Cut a hang short
  initial
  begin
    #1600000;
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
